// >>> design/ssp_defines.svh
// Constants of the serial slave port: header layout, map offsets, timing
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// First byte of a transfer
`define SSP_HDR_RW_BIT        7
`define SSP_HDR_BURST_BIT     6
`define SSP_ADDR_W            6
`define SSP_MAP_DEPTH         64

// Format register and its wire-count bit
`define SSP_FMT_ADDR          6'h31
`define SSP_FMT_3W_BIT        6

// Timing
`define SSP_CLK_PERIOD_NS     10
`define SSP_SCLK_MAX_KHZ      5000
`define SSP_SCLK_MIN_PER_NS   (1000000 / `SSP_SCLK_MAX_KHZ)
`define SSP_HALF_CYC  ((`SSP_SCLK_MIN_PER_NS / 2 + `SSP_CLK_PERIOD_NS - 1) / `SSP_CLK_PERIOD_NS)
`define SSP_SELECT_IDLE_GAP_NS 150
`define SSP_GAP_CYC  ((`SSP_SELECT_IDLE_GAP_NS + `SSP_CLK_PERIOD_NS - 1) / `SSP_CLK_PERIOD_NS)

`endif

// >>> design/ssp_dev.sv
// Sensor end: serial slave with 64-byte register map on the link clock
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_dev (
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    ssp_link_if.dev         link,
    output logic            MODE_TWO_WIRE_O,
    output logic            THREE_WIRE_O,
    output logic            WR_VALID_O,
    output logic [5:0]      WR_ADDR_O,
    output logic [7:0]      WR_DATA_O
);

    ssp_pkg::ssp_drx_t  rx_q, rx_d;
    ssp_pkg::ssp_dtx_t  tx_q, tx_d;
    ssp_pkg::ssp_dusr_t us_q, us_d;
    logic [7:0]         mem_q [`SSP_MAP_DEPTH];
    logic [7:0]         rx_byte;
    logic               wr_en;
    logic               fmt_3w;
    logic               ev_tog_q = 1'b0;
    logic [5:0]         ev_addr_q;
    logic [7:0]         ev_data_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive side, rising edge of the link clock

    assign fmt_3w  = mem_q[`SSP_FMT_ADDR][`SSP_FMT_3W_BIT];
    assign rx_byte = {rx_q.sh, link.sdio};

    always_comb begin
        rx_d       = rx_q;
        wr_en      = 1'b0;
        rx_d.bit_cnt = rx_q.bit_cnt + 3'h1;
        rx_d.sh      = rx_byte[6:0];
        if (rx_q.bit_cnt == 3'h7) begin
            if (!rx_q.hdr_done) begin
                rx_d.hdr_done = 1'b1;
                rx_d.rw       = rx_byte[`SSP_HDR_RW_BIT];
                rx_d.burst    = rx_byte[`SSP_HDR_BURST_BIT];
                rx_d.ptr      = rx_byte[`SSP_ADDR_W-1:0];
            end else if (!rx_q.stop) begin
                wr_en     = !rx_q.rw;
                rx_d.stop = !rx_q.burst;
                if (rx_q.burst) begin
                    rx_d.ptr = rx_q.ptr + 6'h1;
                end
            end
        end
    end

    // frame logic held idle while select high
    // traffic outside a frame is ignored
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            rx_q <= '0;
        end else begin
            rx_q <= rx_d;
        end
    end

    // Map and write event words carry no reset, like a RAM
    always_ff @(posedge link.sclk) begin
        if (wr_en && !link.cs_n) begin
            mem_q[rx_q.ptr] <= rx_byte;
            ev_addr_q       <= rx_q.ptr;
            ev_data_q       <= rx_byte;
            ev_tog_q        <= !ev_tog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit side, falling edge of the link clock

    always_comb begin
        tx_d         = tx_q;
        tx_d.sh      = {tx_q.sh[6:0], 1'b0};
        tx_d.oe_sdo  = 1'b0;
        tx_d.oe_sdio = 1'b0;
        // drive only in read data phase
        if (rx_q.hdr_done && rx_q.rw && !rx_q.stop) begin
            tx_d.oe_sdo  = !fmt_3w;
            tx_d.oe_sdio = fmt_3w;
            if (rx_q.bit_cnt == 3'h0) begin
                tx_d.sh = mem_q[rx_q.ptr];
            end
        end
    end

    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end

    assign link.d_sdo_o   = tx_q.sh[7];
    assign link.d_sdo_oe  = tx_q.oe_sdo;
    assign link.d_sdio_o  = tx_q.sh[7];
    assign link.d_sdio_oe = tx_q.oe_sdio;

    ////////////////////////////////////////////////////////////////////////
    // User side on CLK_I

    always_comb begin
        us_d          = us_q;
        us_d.cs_s1    = link.cs_n;
        us_d.cs_s2    = us_q.cs_s1;
        us_d.fmt_s1   = fmt_3w;
        us_d.fmt_s2   = us_q.fmt_s1;
        us_d.ev_s1    = ev_tog_q;
        us_d.ev_s2    = us_q.ev_s1;
        us_d.ev_s3    = us_q.ev_s2;
        us_d.mode     = us_q.cs_s2;
        us_d.three    = us_q.fmt_s2;
        us_d.wr_valid = 1'b0;
        // a write not yet seen is overtaken by the next
        if (us_q.ev_s2 != us_q.ev_s3) begin
            us_d.wr_valid = 1'b1;
            us_d.addr     = ev_addr_q;
            us_d.data     = ev_data_q;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            us_q <= '0;
        end else begin
            us_q <= us_d;
        end
    end

    assign MODE_TWO_WIRE_O = us_q.mode;
    assign THREE_WIRE_O    = us_q.three;
    assign WR_VALID_O      = us_q.wr_valid;
    assign WR_ADDR_O       = us_q.addr;
    assign WR_DATA_O       = us_q.data;

endmodule // ssp_dev

// >>> design/ssp_host.sv
// Host end: SPI master for the sensor port, clock made by a divider
//
// Operation
// - Select high means two-wire mode
// - Select always driven, never floating
// - Host ignores read line during writes
// - Format bit D6 chooses three-wire
// - Polarity 1, phase 1, at most 5 MHz
// - Select high before clock settings change
// - Select low starts, high ends transfer
// - Clock idles high between transfers
// - Change data on fall, capture on rise
// - Burst flag set for multi-byte transfers
// - Pointer advances after every data byte; the device advances it in burst transfers only
// - New address needs a new transfer
// - Select high at least 150 ns
// - Device drives only during reads
// - Clock fast enough for data rate
// - Slow bus may lose samples
// - Shared bus traffic may confuse device
// - Data line forced high while deselected
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_host #(
    // divider sets link rate
    // Raise either count only up to 256, the 8-bit divider limit; lowering breaks or
    parameter int HALF_CYC = `SSP_HALF_CYC,
    parameter int GAP_CYC  = `SSP_GAP_CYC
) (
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    ssp_link_if.host        link,
    input  wire logic       REQ_VALID_I,
    input  wire logic       REQ_READ_I,
    input  wire logic [5:0] REQ_ADDR_I,
    input  wire logic [6:0] REQ_LEN_I,
    input  wire logic       THREE_WIRE_I,
    input  wire logic [7:0] TX_DATA_I,
    output logic            REQ_READY_O,
    output logic            TX_TAKE_O,
    output logic            RX_VALID_O,
    output logic [7:0]      RX_DATA_O,
    output logic            DONE_O
);

    ssp_pkg::ssp_host_t h_q, h_d;
    logic               tick;
    logic               line_in;
    logic               last_byte;
    logic               rd_phase;

    ////////////////////////////////////////////////////////////////////////
    // Return lines from the device

    // Each line has its own two flops ahead of the mode mux, so a line
    // that is still settling never reaches the shift logic
    // Read data arrives on the shared line in three-wire mode
    assign line_in   = h_q.three ? h_q.sync2[1] : h_q.sync2[0];

    ////////////////////////////////////////////////////////////////////////
    // Next state

    assign tick      = (h_q.div == 8'h00);
    assign last_byte = (h_q.byte_cnt == h_q.len);
    assign rd_phase  = h_q.rw && (h_q.byte_cnt != 7'h00);

    always_comb begin
        h_d          = h_q;
        // Shared line in the upper bit, four-wire return in the lower
        h_d.sync1    = {link.sdio, link.sdo};
        h_d.sync2    = h_q.sync1;
        h_d.tx_take  = 1'b0;
        h_d.rx_valid = 1'b0;
        h_d.done     = 1'b0;
        if (!tick) begin
            h_d.div = h_q.div - 8'h01;
        end

        case (h_q.st)
            ssp_pkg::SSP_IDLE: begin
                if (REQ_VALID_I && h_q.ready) begin
                    h_d.cs_n     = 1'b0;
                    h_d.ready    = 1'b0;
                    h_d.rw       = REQ_READ_I;
                    h_d.three    = THREE_WIRE_I;
                    // Lengths past the map depth wrap the device pointer
                    h_d.len      = REQ_LEN_I;
                    h_d.bit_cnt  = 3'h0;
                    h_d.byte_cnt = 7'h00;
                    // burst flag when more than one byte
                    h_d.tx_sh    = {REQ_READ_I, (REQ_LEN_I > 7'h01), REQ_ADDR_I};
                    h_d.div      = 8'(HALF_CYC - 1);
                    h_d.st       = ssp_pkg::SSP_LEAD;
                end
            end

            ssp_pkg::SSP_LEAD: begin
                if (tick) begin
                    h_d.st = ssp_pkg::SSP_SHIFT;
                end
            end

            ssp_pkg::SSP_SHIFT: begin
                if (tick) begin
                    h_d.div = 8'(HALF_CYC - 1);
                    if (h_q.sclk) begin
                        h_d.sclk = 1'b0;
                        // Four-wire reads keep driving zeros here
                        h_d.mosi = h_q.tx_sh[7];
                        // release shared line for read data
                        h_d.mosi_oe = !(h_q.three && rd_phase);
                    end else begin
                        h_d.sclk    = 1'b1;
                        h_d.rx_sh   = {h_q.rx_sh[6:0], line_in};
                        h_d.tx_sh   = {h_q.tx_sh[6:0], 1'b0};
                        h_d.bit_cnt = h_q.bit_cnt + 3'h1;
                        if (h_q.bit_cnt == 3'h7) begin
                            // read line is dropped on writes
                            if (rd_phase) begin
                                h_d.rx_valid = 1'b1;
                                h_d.rx_data  = {h_q.rx_sh[6:0], line_in};
                            end
                            if (last_byte) begin
                                h_d.st = ssp_pkg::SSP_TAIL;
                            end else begin
                                h_d.byte_cnt = h_q.byte_cnt + 7'h01;
                                if (!h_q.rw) begin
                                    h_d.tx_sh   = TX_DATA_I;
                                    h_d.tx_take = 1'b1;
                                end
                            end
                        end
                    end
                end
            end

            ssp_pkg::SSP_TAIL: begin
                if (tick) begin
                    // each address needs its own frame
                    h_d.cs_n    = 1'b1;
                    h_d.mosi    = 1'b1;
                    h_d.mosi_oe = 1'b1;
                    h_d.done    = 1'b1;
                    h_d.div     = 8'(GAP_CYC - 1);
                    h_d.st      = ssp_pkg::SSP_GAP;
                end
            end

            ssp_pkg::SSP_GAP: begin
                if (tick) begin
                    // Requests wait out the gap rather than queue
                    h_d.ready = 1'b1;
                    h_d.st    = ssp_pkg::SSP_IDLE;
                end
            end

            default: begin
                h_d.st = ssp_pkg::SSP_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            h_q         <= '0;
            h_q.cs_n    <= 1'b1;
            h_q.sclk    <= 1'b1;
            h_q.mosi    <= 1'b1;
            h_q.mosi_oe <= 1'b1;
            h_q.ready   <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state register

    assign link.cs_n      = h_q.cs_n;
    assign link.sclk      = h_q.sclk;
    assign link.h_sdio_o  = h_q.mosi;
    assign link.h_sdio_oe = h_q.mosi_oe;

    assign REQ_READY_O = h_q.ready;
    assign TX_TAKE_O   = h_q.tx_take;
    assign RX_VALID_O  = h_q.rx_valid;
    assign RX_DATA_O   = h_q.rx_data;
    assign DONE_O      = h_q.done;

endmodule // ssp_host

// >>> design/ssp_link_if.sv
// Pins between host master and sensor port, with wire resolution
`timescale 1ns/1ps
interface ssp_link_if;
    logic cs_n;
    logic sclk;
    logic h_sdio_o;
    logic h_sdio_oe;
    logic d_sdio_o;
    logic d_sdio_oe;
    logic d_sdo_o;
    logic d_sdo_oe;
    logic sdio;
    logic sdo;

    // Undriven lines read high, as with a pull-up
    assign sdio = h_sdio_oe ? h_sdio_o : (d_sdio_oe ? d_sdio_o : 1'b1);
    assign sdo  = d_sdo_oe ? d_sdo_o : 1'b1;

    modport host (
        output cs_n,
        output sclk,
        output h_sdio_o,
        output h_sdio_oe,
        input  sdio,
        input  sdo
    );

    modport dev (
        input  cs_n,
        input  sclk,
        input  sdio,
        output d_sdio_o,
        output d_sdio_oe,
        output d_sdo_o,
        output d_sdo_oe
    );
endinterface // ssp_link_if

// >>> design/ssp_pkg.sv
// Types shared by both ends of the serial slave port
package ssp_pkg;

    typedef enum logic [2:0] {
        SSP_IDLE  = 3'h0,
        SSP_LEAD  = 3'h1,
        SSP_SHIFT = 3'h3,
        SSP_TAIL  = 3'h2,
        SSP_GAP   = 3'h6
    } ssp_hstate_t;

    typedef struct packed {
        ssp_hstate_t st;
        logic [7:0]  div;
        logic [2:0]  bit_cnt;
        logic [6:0]  byte_cnt;
        logic [6:0]  len;
        logic        rw;
        logic        three;
        logic [7:0]  tx_sh;
        logic [7:0]  rx_sh;
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic        cs_n;
        logic        sclk;
        logic        mosi;
        logic        mosi_oe;
        logic        ready;
        logic        tx_take;
        logic        rx_valid;
        logic [7:0]  rx_data;
        logic        done;
    } ssp_host_t;

    typedef struct packed {
        logic       hdr_done;
        logic       rw;
        logic       burst;
        logic       stop;
        logic [2:0] bit_cnt;
        logic [5:0] ptr;
        logic [6:0] sh;
    } ssp_drx_t;

    typedef struct packed {
        logic [7:0] sh;
        logic       oe_sdo;
        logic       oe_sdio;
    } ssp_dtx_t;

    typedef struct packed {
        logic       cs_s1;
        logic       cs_s2;
        logic       fmt_s1;
        logic       fmt_s2;
        logic       ev_s1;
        logic       ev_s2;
        logic       ev_s3;
        logic       mode;
        logic       three;
        logic       wr_valid;
        logic [5:0] addr;
        logic [7:0] data;
    } ssp_dusr_t;

endpackage

// >>> testbench/ssp_link_checker.sv
// Link-level assertions for the serial slave port pins
`timescale 1ns/1ps
module ssp_link_checker #(
    parameter int HALF_CYC = 10,
    parameter int GAP_CYC  = 15
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic h_sdio_o,
    input wire logic h_sdio_oe,
    input wire logic d_sdio_o,
    input wire logic d_sdio_oe,
    input wire logic d_sdo_o,
    input wire logic d_sdo_oe,
    input wire logic sdio,
    input wire logic sdo
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic       sclk_q;
    logic       rd_q;
    logic [7:0] run_q;
    logic [7:0] hi_q;
    logic [9:0] rise_q;
    ////////////////////////////////////////////////////////////
    // Run lengths saturate so long idle periods never wrap
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sclk_q <= 1'b1;
            rd_q   <= 1'b0;
            run_q  <= 8'h00;
            hi_q   <= 8'hff;
            rise_q <= 10'h000;
        end else begin
            sclk_q <= sclk;
            run_q  <= (sclk != sclk_q) ? 8'h00 : ((run_q == 8'hff) ? run_q : run_q + 8'h01);
            hi_q   <= !cs_n ? 8'h00 : ((hi_q == 8'hff) ? hi_q : hi_q + 8'h01);
            if (cs_n) begin
                rise_q <= 10'h000;
            end else if (sclk && !sclk_q) begin
                rise_q <= rise_q + 10'h001;
                if (rise_q == 10'h000) begin
                    rd_q <= sdio;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////
    property p_sclk_idle; cs_n |-> sclk; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock not high while deselected");
    property p_lead; $fell(cs_n) |-> sclk [*8]; endproperty
    a_lead: assert property (p_lead) else $error("clock moved right after select");
    property p_tail; $rose(cs_n) |-> $past(sclk, 1) && $past(sclk, 8); endproperty
    a_tail: assert property (p_tail) else $error("select rose too soon after clock");
    property p_half; (sclk != sclk_q && !cs_n) |-> run_q >= HALF_CYC - 1; endproperty
    a_half: assert property (p_half) else $error("link clock phase too short");
    property p_gap; $fell(cs_n) |-> hi_q >= GAP_CYC; endproperty
    a_gap: assert property (p_gap) else $error("deselect gap too short");
    property p_host_stable;
        ($changed(h_sdio_o) && !cs_n && !$past(cs_n)) |-> !$rose(sclk);
    endproperty
    a_host_stable: assert property (p_host_stable) else $error("host data moved on rise");
    property p_dev_fall;
        (($changed(d_sdo_o) && d_sdo_oe && $past(d_sdo_oe))
         || ($changed(d_sdio_o) && d_sdio_oe && $past(d_sdio_oe))) |-> $fell(sclk);
    endproperty
    a_dev_fall: assert property (p_dev_fall) else $error("device data moved off a fall");
    property p_turn; ($rose(d_sdo_oe) || $rose(d_sdio_oe)) |-> $fell(sclk) && rise_q >= 10'd8;
    endproperty
    a_turn: assert property (p_turn) else $error("device drove before header end");
    property p_rd_only; (d_sdo_oe || d_sdio_oe) |-> rd_q; endproperty
    a_rd_only: assert property (p_rd_only) else $error("device drove during a write");
    property p_idle_quiet; (cs_n && $past(cs_n)) |-> !d_sdo_oe && !d_sdio_oe; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("device drove deselected");
    property p_no_clash; !(h_sdio_oe && d_sdio_oe) && !(d_sdo_oe && d_sdio_oe); endproperty
    a_no_clash: assert property (p_no_clash) else $error("data line driven twice");
    c_rd4: cover property ($rose(d_sdo_oe));
    c_rd3: cover property ($rose(d_sdio_oe));
    c_burst: cover property ($rose(cs_n) && rise_q == 10'd40);
    c_hdr: cover property ($rose(cs_n) && rise_q == 10'd8);
endmodule // ssp_link_checker

// >>> testbench/tb_top.sv
// Self-checking bench joining host end and sensor end over the link
`timescale 1ns/1ps
module tb_top;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       rq_v  = 1'b0;
    logic       rq_rd = 1'b0;
    logic       three = 1'b0;
    logic [5:0] rq_a  = 6'h00;
    logic [6:0] rq_n  = 7'h00;
    logic [7:0] txd   = 8'h00;
    logic       take, rxv, done, rdy, mode, thr, wrv, mid;
    logic [5:0] wa;
    logic [7:0] rxd, wd, hdr;
    logic [7:0] wq[$], rdq[$], wdq[$];
    logic [5:0] waq[$];
    int         err_count = 0;
    int         check_count = 0;
    int         nbit = 0;
    initial forever #5 clk_i = ~clk_i;
    ssp_link_if link();
    ssp_host #(.HALF_CYC(10), .GAP_CYC(15)) i_ssp_host(.CLK_I(clk_i), .RST_I(rst_i),
        .link(link), .REQ_VALID_I(rq_v), .REQ_READ_I(rq_rd), .REQ_ADDR_I(rq_a),
        .REQ_LEN_I(rq_n), .THREE_WIRE_I(three), .TX_DATA_I(txd), .REQ_READY_O(rdy),
        .TX_TAKE_O(take), .RX_VALID_O(rxv), .RX_DATA_O(rxd), .DONE_O(done));
    ssp_dev i_ssp_dev(.CLK_I(clk_i), .RST_I(rst_i), .link(link), .MODE_TWO_WIRE_O(mode),
        .THREE_WIRE_O(thr), .WR_VALID_O(wrv), .WR_ADDR_O(wa), .WR_DATA_O(wd));
    ssp_link_checker #(.HALF_CYC(10), .GAP_CYC(15)) i_ssp_link_checker(.CLK_I(clk_i),
        .RST_I(rst_i), .cs_n(link.cs_n), .sclk(link.sclk), .h_sdio_o(link.h_sdio_o),
        .h_sdio_oe(link.h_sdio_oe), .d_sdio_o(link.d_sdio_o), .d_sdio_oe(link.d_sdio_oe),
        .d_sdo_o(link.d_sdo_o), .d_sdo_oe(link.d_sdo_oe), .sdio(link.sdio), .sdo(link.sdo));
    ////////////////////////////////////////////////////////////
    // Header is taken straight off the wire, not from either end
    always @(posedge link.sclk) begin
        if (link.cs_n === 1'b0 && nbit < 8) begin
            hdr <= {hdr[6:0], link.sdio};
            nbit++;
        end
    end
    always @(posedge clk_i) begin
        if (wrv === 1'b1) begin
            waq.push_back(wa);
            wdq.push_back(wd);
        end
    end
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Write bytes come from wq; next byte is staged one edge after each take
    task automatic xfer(input logic rd, input logic [5:0] a, input logic [6:0] n,
                        input logic tw);
        int  i;
        int  j;
        bit  nx;
        bit  dn;
        i = 0;
        nx = 0;
        dn = 0;
        rdq.delete();
        waq.delete();
        wdq.delete();
        @(posedge clk_i);
        nbit = 0;
        txd <= (wq.size() > 0) ? wq[0] : 8'h00;
        rq_v <= 1'b1;
        rq_rd <= rd;
        rq_a <= a;
        rq_n <= n;
        three <= tw;
        @(posedge clk_i);
        rq_v <= 1'b0;
        for (j = 0; j < 3000; j++) begin
            @(posedge clk_i);
            if (nx) txd <= (i < wq.size()) ? wq[i] : 8'h00;
            nx = 0;
            #1;
            if (j == 100) mid = mode;
            if (take === 1'b1) begin
                i++;
                nx = 1;
            end
            if (rxv === 1'b1) rdq.push_back(rxd);
            if (done === 1'b1) dn = 1;
            if (rdy === 1'b1) break;
        end
        if (j == 3000) begin
            err_count++;
            $display("MISMATCH ready expected 1 seen 0");
            end_of_test();
        end
        chk1("done seen", 1'b1, dn);
        chk8("take count", rd ? 8'h00 : {1'b0, n}, 8'(i));
    endtask
    task automatic exp_wr(input logic [5:0] a);
        chk8("write count", 8'(wq.size()), 8'(waq.size()));
        foreach (wq[k]) begin
            chk8("write addr", {2'b00, a + 6'(k)}, {2'b00, waq[k]});
            chk8("write data", wq[k], wdq[k]);
        end
    endtask
    task automatic exp_rd;
        chk8("read count", 8'(wq.size()), 8'(rdq.size()));
        foreach (wq[k]) chk8("read data", wq[k], rdq[k]);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_single;
        wq = '{8'h00};
        xfer(1'b0, 6'h31, 7'h01, 1'b0);
        chk8("header", 8'h31, hdr);
        exp_wr(6'h31);
        chk1("mode in frame", 1'b0, mid);
        chk1("mode idle", 1'b1, mode);
        chk1("three wire", 1'b0, thr);
        chk1("sclk idle", 1'b1, link.sclk);
        $display("Test single write done");
    endtask
    // Start near the top of the map so the pointer wraps mid-burst
    task automatic t_burst;
        wq = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
        xfer(1'b0, 6'h3e, 7'h04, 1'b0);
        chk8("header", 8'h7e, hdr);
        exp_wr(6'h3e);
        xfer(1'b1, 6'h3e, 7'h04, 1'b0);
        chk8("header", 8'hfe, hdr);
        exp_rd();
        chk8("writes on read", 8'h00, 8'(waq.size()));
        wq = '{8'h5a};
        xfer(1'b1, 6'h3f, 7'h01, 1'b0);
        chk8("header", 8'hbf, hdr);
        exp_rd();
        $display("Test burst done");
    endtask
    task automatic t_hdr_only;
        wq.delete();
        xfer(1'b0, 6'h10, 7'h00, 1'b0);
        chk8("header", 8'h10, hdr);
        exp_wr(6'h10);
        $display("Test header only done");
    endtask
    task automatic t_three;
        wq = '{8'h40};
        xfer(1'b0, 6'h31, 7'h01, 1'b0);
        chk1("three wire", 1'b1, thr);
        wq = '{8'h96, 8'h69};
        xfer(1'b0, 6'h05, 7'h02, 1'b1);
        exp_wr(6'h05);
        xfer(1'b1, 6'h05, 7'h02, 1'b1);
        exp_rd();
        wq = '{8'h00};
        xfer(1'b0, 6'h31, 7'h01, 1'b1);
        chk1("three wire", 1'b0, thr);
        $display("Test three wire done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_single();
        t_burst();
        t_hdr_only();
        t_three();
        end_of_test();
    end
endmodule // tb_top
